// file: logic/cis_defs.svh
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH

// Source vector numbering: bit n of a source vector is vector number n
`define CIS_NSRC 16
`define CIS_SRC_IDX_W 4
// Vector numbers 0 (reset) and 1 (software interrupt) carry no hardware flag
`define CIS_HW_SRC_MASK 16'hFFFC
`define CIS_SWI_VEC_NUM 4'h1
// Vector n sits at top minus two times n; high byte at the lower address
`define CIS_VEC_TOP 16'hDFFE
`define CIS_VEC_LO_OFS 16'h0001

// Condition code register layout
`define CIS_CCR_I_BIT 3
`define CIS_CCR_RESET 8'h08

// Stack frame and instruction queue sizes
`define CIS_FRAME_BYTES 3'h5
`define CIS_FRAME_LAST 3'h4
`define CIS_QUEUE_LAST 3'h2

`endif

// file: logic/cis_pkg.sv
package cis_pkg;

    typedef enum logic [2:0] {
        CIS_ST_IDLE,
        CIS_ST_PUSH,
        CIS_ST_VEC,
        CIS_ST_VWAIT,
        CIS_ST_POP,
        CIS_ST_PWAIT,
        CIS_ST_FILL,
        CIS_ST_FIN
    } cis_state_type;

    // Destination of a byte returned by a read cycle
    typedef enum logic [2:0] {
        CIS_TAG_CCR,
        CIS_TAG_A,
        CIS_TAG_X,
        CIS_TAG_PCH,
        CIS_TAG_PCL,
        CIS_TAG_VHI,
        CIS_TAG_VLO,
        CIS_TAG_QUEUE
    } cis_tag_type;

endpackage

// file: logic/cis_sequencer.sv
`timescale 1ns/1ns
`include "cis_defs.svh"

// Behaviour
// RULE1: A hardware event pulse sets that source's read-only status flag.
// RULE2: A set flag requests the CPU only while its local enable is 1.
// RULE3: Maskable requests are taken only while the global mask bit is 0.
// RULE4: Reset sets the global mask bit, blocking every maskable source.
// RULE5: The response starts only at an instruction boundary.
// RULE6: Stack order is PC low, PC high, index low, accumulator, condition codes.
// RULE7: After stacking the global mask bit is set, preventing nesting.
// RULE8: The vector of the highest-priority request pending at fetch time is used.
// RULE9: After the vector, three program bytes fill the queue from the handler.
// RULE10: After stacking, stack pointer is one below the condition code byte.
// RULE11: Stacked PC is the address of the next main-program instruction.
// RULE12: Return unstacks in reverse order, then prefetches three bytes.
// RULE13: Index high byte is never stacked nor restored.
// RULE14: The source whose vector lies at the higher address wins.
// RULE15: Vector high byte is read at the lower address, low byte above.
// RULE16: Software interrupt runs the same cycle sequence as hardware.
// RULE17: Any vector fetch pulses the wake output, leaving every stop mode.
// RULE18: Software clears the causing flag before returning from the handler.
// RULE19: A request stays while flag and enable are set, drops on clear.
module cis_sequencer
    import cis_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [15:0] i_event,
    input wire logic [15:0] i_flag_clr,
    input wire logic [15:0] i_enable,
    input wire logic i_insn_done,
    input wire logic i_swi,
    input wire logic i_rti,
    input wire logic i_ccr_wr,
    input wire logic [7:0] i_ccr_wdata,
    input wire logic [15:0] i_pc,
    input wire logic [15:0] i_sp,
    input wire logic [7:0] i_x,
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_mem_rdata,
    output logic [15:0] o_flags,
    output logic [15:0] o_req,
    output logic o_irq,
    output logic o_busy,
    output logic [15:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_mem_we,
    output logic o_mem_re,
    output logic o_wake,
    output logic [3:0] o_vec_num,
    output logic [7:0] o_queue_data,
    output logic o_queue_valid,
    output logic o_done,
    output logic [15:0] o_pc,
    output logic [15:0] o_sp,
    output logic [7:0] o_x,
    output logic [7:0] o_a,
    output logic [7:0] o_ccr
);

    // Highest priority is the lowest vector number, the highest address
    function automatic logic [3:0] cis_pick(input logic [15:0] pend);
        logic [3:0] idx;
        idx = 4'hF;
        for (int n = 15; n >= 0; n--) begin
            if (pend[n]) begin
                idx = 4'(n); // RULE14
            end
        end
        return idx;
    endfunction

    // Address of the high byte of a vector
    function automatic logic [15:0] cis_vec_addr(input logic [3:0] num);
        return `CIS_VEC_TOP - {11'h000, num, 1'b0};
    endfunction

    cis_state_type state_r;
    cis_tag_type rd_tag_r;
    logic [2:0] cnt_r;
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    logic [15:0] req_r;
    logic irq_r;
    logic [7:0] ccr_r;
    logic [15:0] pc_r;
    logic [15:0] sp_r;
    logic [7:0] x_r;
    logic [7:0] a_r;
    logic [7:0] ccr_save_r;
    logic [7:0] vec_hi_r;
    logic [3:0] src_r;
    logic [15:0] mem_addr_r;
    logic [7:0] mem_wdata_r;
    logic mem_we_r;
    logic mem_re_r;
    logic wake_r;
    logic [7:0] q_data_r;
    logic q_valid_r;
    logic done_r;
    logic busy_r;

    // Flag update: an event in the clearing cycle wins over the clear
    assign flags_nxt = ((flags_r & ~i_flag_clr) | i_event) & `CIS_HW_SRC_MASK; // RULE1 RULE18

    // Request qualification and boundary decision
    // A take needs idle state and a boundary strobe from the core.
    // Return beats software interrupt, which beats a hardware request.
    // The software interrupt ignores the mask bit, like the real opcode.
    // Hardware requests are gated by the global mask bit only here.
    wire [15:0] pending = flags_r & i_enable; // RULE2
    wire irq_ok = (|pending) && !ccr_r[`CIS_CCR_I_BIT]; // RULE3
    wire take_rti = (state_r == CIS_ST_IDLE) && i_insn_done && i_rti; // RULE5
    wire take_swi = (state_r == CIS_ST_IDLE) && i_insn_done && !i_rti && i_swi; // RULE16
    wire take_irq = (state_r == CIS_ST_IDLE) && i_insn_done && !i_rti && !i_swi && irq_ok;
    wire [3:0] now_pick = cis_pick(pending);
    wire [3:0] vec_num = (src_r != `CIS_SWI_VEC_NUM && (|pending)) ? now_pick : src_r; // RULE8
    wire last_frame = (cnt_r == `CIS_FRAME_LAST);
    wire last_fill = (cnt_r == `CIS_QUEUE_LAST);

    // Byte pushed at each frame step
    // The step counter walks the frame from program counter low downward in memory.
    // Index high is left out on purpose; handlers save it themselves.
    wire [7:0] push_byte = (cnt_r == 3'h0) ? pc_r[7:0] :
                           (cnt_r == 3'h1) ? pc_r[15:8] :
                           (cnt_r == 3'h2) ? x_r :
                           (cnt_r == 3'h3) ? a_r : ccr_save_r; // RULE6 RULE13
    wire [15:0] push_addr = sp_r - {13'h0000, cnt_r};
    wire [15:0] pop_addr = sp_r + {13'h0000, cnt_r} + 16'h0001;
    // Reverse order of the frame on return
    wire cis_tag_type pop_tag = (cnt_r == 3'h0) ? CIS_TAG_CCR :
                                (cnt_r == 3'h1) ? CIS_TAG_A :
                                (cnt_r == 3'h2) ? CIS_TAG_X :
                                (cnt_r == 3'h3) ? CIS_TAG_PCH : CIS_TAG_PCL; // RULE12

    // Status flags and request lines
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_r <= 16'h0000;
            req_r <= 16'h0000;
            irq_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt; // RULE1
            req_r <= flags_nxt & i_enable; // RULE19
            irq_r <= |(flags_nxt & i_enable); // RULE2
        end
    end

    // Sequencer state and step counter
    // Entry: five pushes, two vector reads, one wait, three queue reads.
    // Return: five pops, one wait, three queue reads.
    // The counter is cleared wherever a phase restarts its numbering.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= CIS_ST_IDLE;
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
            case (state_r)
                CIS_ST_IDLE: begin
                    cnt_r <= 3'h0;
                    if (take_rti) begin
                        state_r <= CIS_ST_POP;
                    end else if (take_swi || take_irq) begin
                        state_r <= CIS_ST_PUSH; // RULE16
                    end
                end
                CIS_ST_PUSH: begin
                    if (last_frame) begin
                        state_r <= CIS_ST_VEC;
                        cnt_r <= 3'h0;
                    end
                end
                CIS_ST_VEC: begin
                    if (cnt_r == 3'h1) begin
                        state_r <= CIS_ST_VWAIT;
                    end
                end
                CIS_ST_POP: begin
                    if (last_frame) begin
                        state_r <= CIS_ST_PWAIT;
                    end
                end
                CIS_ST_VWAIT, CIS_ST_PWAIT: begin
                    state_r <= CIS_ST_FILL;
                    cnt_r <= 3'h0;
                end
                CIS_ST_FILL: begin
                    if (last_fill) begin
                        state_r <= CIS_ST_FIN; // RULE9
                    end
                end
                default: begin
                    state_r <= CIS_ST_IDLE;
                end
            endcase
        end
    end

    // Memory cycle issue; every command shows on the port the next cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mem_addr_r <= 16'h0000;
            mem_wdata_r <= 8'h00;
            mem_we_r <= 1'b0;
            mem_re_r <= 1'b0;
            rd_tag_r <= CIS_TAG_CCR;
            wake_r <= 1'b0;
            src_r <= 4'h0;
        end else begin
            mem_we_r <= 1'b0;
            mem_re_r <= 1'b0;
            wake_r <= 1'b0;
            case (state_r)
                CIS_ST_IDLE: begin
                    src_r <= take_swi ? `CIS_SWI_VEC_NUM : now_pick;
                end
                CIS_ST_PUSH: begin
                    mem_addr_r <= push_addr; // RULE6
                    mem_wdata_r <= push_byte;
                    mem_we_r <= 1'b1;
                end
                CIS_ST_VEC: begin
                    if (cnt_r == 3'h0) begin
                        src_r <= vec_num; // RULE8
                        mem_addr_r <= cis_vec_addr(vec_num); // RULE15
                        rd_tag_r <= CIS_TAG_VHI;
                        wake_r <= 1'b1; // RULE17
                    end else begin
                        mem_addr_r <= cis_vec_addr(src_r) + `CIS_VEC_LO_OFS; // RULE15
                        rd_tag_r <= CIS_TAG_VLO;
                    end
                    mem_re_r <= 1'b1;
                end
                CIS_ST_POP: begin
                    mem_addr_r <= pop_addr; // RULE12
                    rd_tag_r <= pop_tag;
                    mem_re_r <= 1'b1;
                end
                CIS_ST_FILL: begin
                    mem_addr_r <= pc_r + {13'h0000, cnt_r}; // RULE9 RULE12
                    rd_tag_r <= CIS_TAG_QUEUE;
                    mem_re_r <= 1'b1;
                end
                default: begin
                    mem_re_r <= 1'b0;
                end
            endcase
        end
    end

    // CPU register image: loaded at the boundary, updated by the sequence
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pc_r <= 16'h0000;
            sp_r <= 16'h0000;
            x_r <= 8'h00;
            a_r <= 8'h00;
            ccr_save_r <= 8'h00;
            vec_hi_r <= 8'h00;
        end else begin
            if (take_rti || take_swi || take_irq) begin
                pc_r <= i_pc; // RULE11
                sp_r <= i_sp;
                x_r <= i_x;
                a_r <= i_a;
                ccr_save_r <= ccr_r;
            end else if (state_r == CIS_ST_PUSH && last_frame) begin
                sp_r <= sp_r - {13'h0000, `CIS_FRAME_BYTES}; // RULE10
            end else if (state_r == CIS_ST_POP && last_frame) begin
                sp_r <= sp_r + {13'h0000, `CIS_FRAME_BYTES}; // RULE12
            end
            if (mem_re_r) begin
                case (rd_tag_r)
                    CIS_TAG_A: a_r <= i_mem_rdata;
                    CIS_TAG_X: x_r <= i_mem_rdata;
                    CIS_TAG_PCH: pc_r[15:8] <= i_mem_rdata;
                    CIS_TAG_PCL: pc_r[7:0] <= i_mem_rdata;
                    CIS_TAG_VHI: vec_hi_r <= i_mem_rdata;
                    CIS_TAG_VLO: pc_r <= {vec_hi_r, i_mem_rdata}; // RULE15
                    default: vec_hi_r <= vec_hi_r;
                endcase
            end
        end
    end

    // Condition codes: mask bit set on reset and after stacking
    // The old value is already in the frame image, so setting it is safe.
    // Software writes are held off while a sequence runs.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ccr_r <= `CIS_CCR_RESET; // RULE4
        end else if (state_r == CIS_ST_PUSH && last_frame) begin
            ccr_r[`CIS_CCR_I_BIT] <= 1'b1; // RULE7
        end else if (mem_re_r && rd_tag_r == CIS_TAG_CCR) begin
            ccr_r <= i_mem_rdata; // RULE12
        end else if (i_ccr_wr && state_r == CIS_ST_IDLE) begin
            ccr_r <= i_ccr_wdata;
        end
    end

    // Queue bytes and completion handshake toward the core
    // Busy rises the cycle after a take and falls the cycle after the final state.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            q_data_r <= 8'h00;
            q_valid_r <= 1'b0;
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            q_valid_r <= mem_re_r && rd_tag_r == CIS_TAG_QUEUE; // RULE9
            if (mem_re_r && rd_tag_r == CIS_TAG_QUEUE) begin
                q_data_r <= i_mem_rdata;
            end
            done_r <= (state_r == CIS_ST_FIN);
            busy_r <= (state_r != CIS_ST_IDLE && state_r != CIS_ST_FIN) ||
                      take_rti || take_swi || take_irq;
        end
    end

    assign o_flags = flags_r;
    assign o_req = req_r;
    assign o_irq = irq_r;
    assign o_busy = busy_r;
    assign o_mem_addr = mem_addr_r;
    assign o_mem_wdata = mem_wdata_r;
    assign o_mem_we = mem_we_r;
    assign o_mem_re = mem_re_r;
    assign o_wake = wake_r;
    assign o_vec_num = src_r;
    assign o_queue_data = q_data_r;
    assign o_queue_valid = q_valid_r;
    assign o_done = done_r;
    assign o_pc = pc_r;
    assign o_sp = sp_r;
    assign o_x = x_r;
    assign o_a = a_r;
    assign o_ccr = ccr_r;

endmodule

// file: sim/cis_sequencer_chk.sv
`timescale 1ns/1ns
// Watches flag gating and the entry and return sequences at the ports
module cis_sequencer_chk (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [15:0] i_event,
    input wire logic [15:0] i_enable,
    input wire logic i_insn_done,
    input wire logic i_swi,
    input wire logic i_rti,
    input wire logic [15:0] i_pc,
    input wire logic [15:0] i_sp,
    input wire logic [15:0] o_flags,
    input wire logic [15:0] o_req,
    input wire logic o_irq,
    input wire logic o_busy,
    input wire logic [15:0] o_mem_addr,
    input wire logic [7:0] o_mem_wdata,
    input wire logic o_mem_we,
    input wire logic o_mem_re,
    input wire logic o_wake,
    input wire logic [3:0] o_vec_num,
    input wire logic o_done,
    input wire logic [15:0] o_sp,
    input wire logic [7:0] o_ccr
);
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    // Flags, requests and the mask bit
    AST_MASK_RST: assert property (!$past(i_rstn) |-> o_ccr[3])
        else $error("mask bit clear after reset");
    AST_FLAG_SET: assert property ($past(i_rstn) |-> o_flags[1:0] == 2'h0 &&
        ((($past(i_event) & 16'hFFFC) & ~o_flags) == 16'h0000))
        else $error("event did not set its flag");
    AST_REQ_GATE: assert property (o_req == (o_flags & $past(i_enable)))
        else $error("request not flag and enable");
    AST_IRQ_OR: assert property (o_irq == (|o_req))
        else $error("irq not or of requests");

    // Taking a sequence
    AST_TAKE_DONE: assert property ($rose(o_busy) |-> $past(i_insn_done))
        else $error("sequence began mid instruction");
    AST_TAKE_MASK: assert property ($rose(o_busy) |->
        $past(i_swi) || $past(i_rti) || !$past(o_ccr[3]))
        else $error("masked request was taken");

    // Entry and return timing and contents
    AST_ENTRY: assert property ($rose(o_busy) && !$past(i_rti) |-> ##12
        (o_done && o_ccr[3] && o_sp == $past(i_sp, 13) - 16'h0005))
        else $error("entry end state wrong");
    AST_RETURN: assert property ($rose(o_busy) && $past(i_rti) |-> ##10 o_done)
        else $error("return length wrong");
    AST_PUSH_PCL: assert property ($rose(o_busy) && !$past(i_rti) |=> o_mem_we &&
        o_mem_addr == $past(i_sp, 2) && o_mem_wdata == $past(i_pc[7:0], 2))
        else $error("first push not pc low at sp");
    AST_WAKE_VEC: assert property (o_wake |-> o_mem_re &&
        o_mem_addr == 16'hDFFE - {11'h000, o_vec_num, 1'b0})
        else $error("wake not at vector read");
    AST_VEC_PAIR: assert property (o_wake |=> o_mem_re &&
        o_mem_addr == $past(o_mem_addr) + 16'h0001)
        else $error("vector low byte not next address");
endmodule

// file: sim/cis_mem_model.sv
`timescale 1ns/1ns
// Memory and vector table as the core side sees them
module cis_mem_model (
    input wire logic i_clk,
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_r [0:65535];
    logic [7:0] last_r;

    // Pattern fill; vector n for 1 to 15 points at handler 0xC0+n : 0x10, high byte first
    initial begin
        for (int a = 0; a < 65536; a++) begin
            mem_r[a] = a[7:0] ^ a[15:8];
        end
        for (int n = 1; n < 16; n++) begin
            mem_r[16'hDFFE - 2 * n] = 8'hC0 + n[7:0];
            mem_r[16'hDFFF - 2 * n] = 8'h10;
        end
        last_r = 8'h00;
    end

    // Writes land at the edge; an idle read bus shows the inverse of the last byte
    always @(posedge i_clk) begin
        if (i_we)
            mem_r[i_addr] <= i_wdata;
        if (i_re)
            last_r <= mem_r[i_addr];
    end
    assign o_rdata = i_re ? mem_r[i_addr] : ~last_r;
endmodule

// file: sim/cis_sequencer_bench.sv
`timescale 1ns/1ns
module cis_sequencer_bench;
    logic i_clk, i_rstn = 1'b0, i_insn_done = 1'b0, i_swi = 1'b0, i_rti = 1'b0;
    logic i_ccr_wr = 1'b0;
    logic [15:0] i_event = 16'h0000, i_flag_clr = 16'h0000, i_enable = 16'h0000;
    logic [15:0] i_pc = 16'h1234, i_sp = 16'h01F0;
    logic [7:0] i_ccr_wdata = 8'h00, i_x = 8'h5A, i_a = 8'hA5, i_mem_rdata;
    logic [15:0] o_flags, o_req, o_mem_addr, o_pc, o_sp;
    logic [7:0] o_mem_wdata, o_queue_data, o_x, o_a, o_ccr;
    logic o_irq, o_busy, o_mem_we, o_mem_re, o_wake, o_queue_valid, o_done;
    logic [3:0] o_vec_num;
    logic [15:0] wa[$], ra[$];
    logic [7:0] wd[$], qd[$];
    int n_mismatch = 0, num_checks = 0, wake_c, done_c;

    cis_sequencer i_cis_sequencer (.i_clk, .i_rstn, .i_event, .i_flag_clr, .i_enable,
        .i_insn_done, .i_swi, .i_rti, .i_ccr_wr, .i_ccr_wdata, .i_pc, .i_sp, .i_x, .i_a,
        .i_mem_rdata, .o_flags, .o_req, .o_irq, .o_busy, .o_mem_addr, .o_mem_wdata,
        .o_mem_we, .o_mem_re, .o_wake, .o_vec_num, .o_queue_data, .o_queue_valid,
        .o_done, .o_pc, .o_sp, .o_x, .o_a, .o_ccr);
    cis_mem_model i_cis_mem_model (.i_clk, .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
        .i_we(o_mem_we), .i_re(o_mem_re), .o_rdata(i_mem_rdata));

    // Clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Start one sequence at an instruction boundary and log what it does per cycle
    task automatic go(input logic software_interrupt_instruction, input logic return_from_interrupt_instruction);
        wa = {};
        wd = {};
        ra = {};
        qd = {};
        wake_c = 0;
        done_c = 0;
        @(posedge i_clk);
        i_insn_done <= 1'b1;
        i_swi <= software_interrupt_instruction;
        i_rti <= return_from_interrupt_instruction;
        @(posedge i_clk);
        i_insn_done <= 1'b0;
        i_swi <= 1'b0;
        i_rti <= 1'b0;
        for (int c = 1; c < 20 && done_c == 0; c++) begin
            @(negedge i_clk);
            if (o_mem_we === 1'b1) begin
                wa.push_back(o_mem_addr);
                wd.push_back(o_mem_wdata);
            end
            if (o_mem_re === 1'b1)
                ra.push_back(o_mem_addr);
            if (o_queue_valid === 1'b1)
                qd.push_back(o_queue_data);
            if (o_wake === 1'b1)
                wake_c = c;
            if (o_done === 1'b1)
                done_c = c;
        end
    endtask

    // Judge an entry with sp 0x01F0, pc 0x1234, x 0x5A, a 0xA5
    task automatic entry(input logic [3:0] n, input logic [7:0] cc);
        logic [15:0] h;
        h = {8'hC0 + {4'h0, n}, 8'h10};
        chk(16'(done_c), 16'h000D);
        chk(16'(wake_c), 16'h0007);
        chk(o_vec_num, n);
        chk(16'(wa.size() + ra.size()), 16'h000A);
        for (int k = 0; k < 5; k++) begin
            chk(wa[k], 16'h01F0 - 16'(k));
        end
        chk({wd[0], wd[1]}, 16'h3412);
        chk({wd[2], wd[3]}, 16'h5AA5);
        chk(wd[4], cc);
        chk(ra[0], 16'hDFFE - {11'h000, n, 1'b0});
        chk(ra[1], 16'hDFFF - {11'h000, n, 1'b0});
        for (int k = 0; k < 3; k++) begin
            chk(ra[k + 2], h + 16'(k));
            chk(qd[k], (h[7:0] + 8'(k)) ^ h[15:8]);
        end
        chk(o_sp, 16'h01EB);
        chk(o_pc, h);
        chk(o_ccr, 8'h08);
    endtask

    task automatic t_flags();
        @(posedge i_clk);
        i_enable <= 16'h00A0;
        i_event <= 16'h00A3;
        @(posedge i_clk);
        i_event <= 16'h0000;
        i_insn_done <= 1'b1;
        @(negedge i_clk);
        chk(o_flags, 16'h00A0);
        chk({o_req[14:0], o_irq}, 16'h0141);
        repeat (3) @(posedge i_clk);
        i_insn_done <= 1'b0;
        i_enable <= 16'h0080;
        repeat (2) @(posedge i_clk);
        i_enable <= 16'h00A0;
        @(negedge i_clk);
        chk(o_req, 16'h0080);
        chk(o_busy, 1'b0);
    endtask

    task automatic t_entry();
        @(posedge i_clk);
        i_ccr_wr <= 1'b1;
        @(posedge i_clk);
        i_ccr_wr <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_busy, 1'b0);
        go(1'b0, 1'b0);
        entry(4'h5, 8'h00);
    endtask

    task automatic t_rti();
        @(posedge i_clk);
        i_flag_clr <= 16'h0020;
        i_sp <= 16'h01EB;
        i_x <= 8'h00;
        i_a <= 8'h00;
        @(posedge i_clk);
        i_flag_clr <= 16'h0000;
        @(negedge i_clk);
        chk(o_req, 16'h0080);
        go(1'b0, 1'b1);
        chk(16'(done_c), 16'h000B);
        chk(o_pc, 16'h1234);
        for (int k = 0; k < 5; k++) begin
            chk(ra[k], 16'h01EC + 16'(k));
        end
        for (int k = 0; k < 3; k++) begin
            chk(ra[k + 5], 16'h1234 + 16'(k));
            chk(qd[k], (8'h34 + 8'(k)) ^ 8'h12);
        end
        chk({o_a, o_x}, 16'hA55A);
        chk({o_ccr, 8'h00}, 16'h0000);
        chk(o_sp, 16'h01F0);
    endtask

    task automatic t_swi();
        @(posedge i_clk);
        i_ccr_wr <= 1'b1;
        i_ccr_wdata <= 8'h08;
        i_sp <= 16'h01F0;
        i_x <= 8'h5A;
        i_a <= 8'hA5;
        @(posedge i_clk);
        i_ccr_wr <= 1'b0;
        go(1'b1, 1'b0);
        entry(4'h1, 8'h08);
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(negedge i_clk);
        chk({o_ccr, o_req[7:0]}, 16'h0800);
        t_flags();
        t_entry();
        t_rti();
        t_swi();
        conclude();
    end

    // Watchdog
    initial begin
        repeat (2000) @(posedge i_clk);
        n_mismatch++;
        conclude();
    end
endmodule

bind cis_sequencer cis_sequencer_chk i_cis_sequencer_chk (.i_clk, .i_rstn, .i_event,
    .i_enable, .i_insn_done, .i_swi, .i_rti, .i_pc, .i_sp, .o_flags, .o_req, .o_irq,
    .o_busy, .o_mem_addr, .o_mem_wdata, .o_mem_we, .o_mem_re, .o_wake, .o_vec_num,
    .o_done, .o_sp, .o_ccr);
